// *** design/sr_latch_input_select.sv ***
// latch set/reset input selection with apb register slave
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sr_latch_input_select
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        i_latch_input_pin,
    input  wire logic        i_comparator_one,
    input  wire logic        i_comparator_two,
    output logic             o_latch_set,
    output logic             o_latch_reset,
    output logic             o_latch_pulse_clock,
    output logic             o_latch_enable_bit,
    output logic             o_true_output_enable,
    output logic             o_inverted_output_enable
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0]                     ctrl_reg;
        logic [7:0]                     enab_reg;
        logic [sr_sel_pkg::DIV_CNT_W-1:0] div_reg;
        logic                           pulse_reg;
        logic                           soft_set_reg;
        logic                           soft_reset_reg;
        logic                           set_reg;
        logic                           reset_reg;
        logic [31:0]                    rdata_reg;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic       access;
    logic       wr_ctrl;
    logic       wr_enab;
    logic       mapped;
    logic [2:0] div_sel;
    logic [sr_sel_pkg::DIV_CNT_W-1:0] div_mask;

    // ==========================================================
    // bus decode; slave answers in the first access cycle
    assign access  = psel && penable;
    assign mapped  = (paddr == sr_sel_pkg::ADDR_CONTROL_MAIN)
                  || (paddr == sr_sel_pkg::ADDR_SOURCE_ENABLES);
    assign wr_ctrl = access && pwrite && pstrb[0]
                  && (paddr == sr_sel_pkg::ADDR_CONTROL_MAIN);
    assign wr_enab = access && pwrite && pstrb[0]
                  && (paddr == sr_sel_pkg::ADDR_SOURCE_ENABLES);
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = st_reg.rdata_reg;

    assign div_sel  = st_reg.ctrl_reg[sr_sel_pkg::DIV_SEL_LSB +: 3];
    // period is 4 << sel; mask of low counter bits gives the pulse point
    // shift amount kept 4 bits wide: sel 7 needs 9, a 3-bit sum would wrap
    assign div_mask = sr_sel_pkg::DIV_CNT_W'((32'd1 << (4'(div_sel)
                    + 4'(sr_sel_pkg::DIV_BASE_LOG2))) - 32'd1);

    // ==========================================================
    // one source nibble: pin, divided clock, comparator two, comparator one
    function automatic logic source_hit
    (
        input logic [3:0] en,
        input logic       pin,
        input logic       pulse,
        input logic       cmp2,
        input logic       cmp1
    );
        return (en[3] && pin)
            || (en[2] && pulse)
            || (en[1] && cmp2)
            || (en[0] && cmp1);
    endfunction : source_hit

    always_comb
    begin
        st_next = st_reg;
        st_next.div_reg   = st_reg.div_reg + 1'b1;
        // one clock wide pulse every (4 << sel) clocks
        st_next.pulse_reg = ((st_reg.div_reg & div_mask) == div_mask);
        st_next.soft_set_reg   = 1'b0;
        st_next.soft_reset_reg = 1'b0;
        if (wr_ctrl)
        begin
            // pulse bits never store, only trigger
            st_next.ctrl_reg = pwdata[7:0] & 8'hfc;
            st_next.soft_set_reg   = pwdata[sr_sel_pkg::BIT_SOFT_SET];
            st_next.soft_reset_reg = pwdata[sr_sel_pkg::BIT_SOFT_RESET];
        end
        if (wr_enab)
            st_next.enab_reg = pwdata[7:0];
        // upper 24 bits and unmapped addresses read zero
        st_next.rdata_reg = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            if (paddr == sr_sel_pkg::ADDR_CONTROL_MAIN)
                st_next.rdata_reg = {24'h00_0000, st_reg.ctrl_reg & 8'hfc};
            else if (paddr == sr_sel_pkg::ADDR_SOURCE_ENABLES)
                st_next.rdata_reg = {24'h00_0000, st_reg.enab_reg};
        end
        // each source gated by its own enable; set and reset may rise together
        // when software enables one source on both, dominance is left to the latch
        st_next.set_reg = source_hit(
            st_reg.enab_reg[sr_sel_pkg::BIT_PIN_SET -: 4],
            i_latch_input_pin,
            st_reg.pulse_reg,
            i_comparator_two,
            i_comparator_one) || st_reg.soft_set_reg;
        st_next.reset_reg = source_hit(
            st_reg.enab_reg[sr_sel_pkg::BIT_PIN_RESET -: 4],
            i_latch_input_pin,
            st_reg.pulse_reg,
            i_comparator_two,
            i_comparator_one) || st_reg.soft_reset_reg;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_reg          <= '0;
            st_reg.ctrl_reg <= sr_sel_pkg::CONTROL_MAIN_RESET;
            st_reg.enab_reg <= sr_sel_pkg::SOURCE_ENABLES_RESET;
        end
        else if (i_clk_en)
            st_reg <= st_next;
    end

    assign o_latch_set              = st_reg.set_reg;
    assign o_latch_reset            = st_reg.reset_reg;
    assign o_latch_pulse_clock      = st_reg.pulse_reg;
    assign o_latch_enable_bit       = st_reg.ctrl_reg[sr_sel_pkg::BIT_LATCH_ENABLE];
    assign o_true_output_enable     = st_reg.ctrl_reg[sr_sel_pkg::BIT_TRUE_OUT_EN];
    assign o_inverted_output_enable = st_reg.ctrl_reg[sr_sel_pkg::BIT_INV_OUT_EN];

    // ==========================================================
    // checks
    sequence soft_set_write_s;
        i_clk_en && wr_ctrl && pwdata[sr_sel_pkg::BIT_SOFT_SET];
    endsequence

    sequence soft_reset_write_s;
        i_clk_en && wr_ctrl && pwdata[sr_sel_pkg::BIT_SOFT_RESET];
    endsequence

    clk_set_follow_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && st_reg.pulse_reg && st_reg.enab_reg[sr_sel_pkg::BIT_CLOCK_SET])
        |=> o_latch_set)
        else $error("clock pulse did not set latch");
    clk_set_block_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && !st_reg.enab_reg[sr_sel_pkg::BIT_CLOCK_SET] && !st_reg.soft_set_reg
            && !(st_reg.enab_reg[sr_sel_pkg::BIT_PIN_SET] && i_latch_input_pin)
            && !(st_reg.enab_reg[sr_sel_pkg::BIT_CMP2_SET] && i_comparator_two)
            && !(st_reg.enab_reg[sr_sel_pkg::BIT_CMP1_SET] && i_comparator_one))
        |=> !o_latch_set)
        else $error("set rose with the clock-set enable off and no other set source");
    soft_set_pulse_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        soft_set_write_s ##1 (i_clk_en [*2]) |-> o_latch_set)
        else $error("soft set pulse missing");
    soft_read_zero_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (psel && penable && !pwrite && paddr == sr_sel_pkg::ADDR_CONTROL_MAIN)
        |-> prdata[1:0] == 2'b00)
        else $error("pulse bits read back nonzero");
    upper_zero_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        st_reg.rdata_reg[31:8] == 24'h00_0000)
        else $error("unimplemented bits nonzero");
    pin_reset_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && i_latch_input_pin && st_reg.enab_reg[sr_sel_pkg::BIT_PIN_RESET])
        |=> o_latch_reset)
        else $error("pin did not reset latch");
    clk_reset_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && st_reg.pulse_reg && st_reg.enab_reg[sr_sel_pkg::BIT_CLOCK_RESET])
        |=> o_latch_reset)
        else $error("clock pulse did not reset latch");
    cmp_gate_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && st_reg.enab_reg == 8'h00 && !st_reg.soft_reset_reg)
        |=> !o_latch_reset)
        else $error("reset asserted with no source enabled");
    soft_reset_pulse_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        soft_reset_write_s ##1 (i_clk_en [*2]) |-> o_latch_reset)
        else $error("soft reset pulse missing");
    pin_set_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && i_latch_input_pin && st_reg.enab_reg[sr_sel_pkg::BIT_PIN_SET])
        |=> o_latch_set)
        else $error("pin did not set latch");
    cmp1_set_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && i_comparator_one && st_reg.enab_reg[sr_sel_pkg::BIT_CMP1_SET])
        |=> o_latch_set)
        else $error("comparator one did not set latch");
    cmp2_set_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && i_comparator_two && st_reg.enab_reg[sr_sel_pkg::BIT_CMP2_SET])
        |=> o_latch_set)
        else $error("comparator two did not set latch");
    cmp1_reset_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && i_comparator_one && st_reg.enab_reg[sr_sel_pkg::BIT_CMP1_RESET])
        |=> o_latch_reset)
        else $error("comparator one did not reset latch");
    cmp2_reset_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && i_comparator_two && st_reg.enab_reg[sr_sel_pkg::BIT_CMP2_RESET])
        |=> o_latch_reset)
        else $error("comparator two did not reset latch");
    clk_reset_block_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && st_reg.enab_reg == 8'h40 && !st_reg.soft_reset_reg)
        |=> !o_latch_reset)
        else $error("clock-set pulse leaked onto the reset input");
    unmapped_write_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && access && pwrite && !mapped)
        |=> ($stable(st_reg.ctrl_reg) && $stable(st_reg.enab_reg)))
        else $error("write to an unmapped address changed a register");
    pulse_single_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && o_latch_pulse_clock)
        |=> !o_latch_pulse_clock)
        else $error("divided clock pulse wider than one cycle");
endmodule : sr_latch_input_select
`default_nettype wire

// *** design/sr_sel_pkg.sv ***
// constants and register map of the latch input selection block
// What this block does
// - clock-set enable 1: each divided-clock pulse drives the latch set input
// - clock-set enable 0: divided-clock pulses never reach the set input
// - soft set/reset pulse bits act on written 1 only, always read 0
// - unimplemented register bits read 0, writes to them do nothing
// - input pin may drive set, reset or both, each under own enable
// - clock-set and clock-reset enables gate the pulse independently
package sr_sel_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [11:0] ADDR_CONTROL_MAIN   = 12'h000;
    localparam logic [11:0] ADDR_SOURCE_ENABLES = 12'h004;
    localparam int          ADDR_W              = 12;

    // ==========================================================
    // latch_control_main fields
    localparam int BIT_LATCH_ENABLE   = 7;
    localparam int DIV_SEL_LSB        = 4;
    localparam int BIT_TRUE_OUT_EN    = 3;
    localparam int BIT_INV_OUT_EN     = 2;
    localparam int BIT_SOFT_SET       = 1;
    localparam int BIT_SOFT_RESET     = 0;

    // ==========================================================
    // latch_source_enables fields
    localparam int BIT_PIN_SET        = 7;
    localparam int BIT_CLOCK_SET      = 6;
    localparam int BIT_CMP2_SET       = 5;
    localparam int BIT_CMP1_SET       = 4;
    localparam int BIT_PIN_RESET      = 3;
    localparam int BIT_CLOCK_RESET    = 2;
    localparam int BIT_CMP2_RESET     = 1;
    localparam int BIT_CMP1_RESET     = 0;

    // ==========================================================
    // reset values and divider
    localparam logic [7:0] CONTROL_MAIN_RESET   = 8'h00;
    localparam logic [7:0] SOURCE_ENABLES_RESET = 8'h00;
    localparam int         DIV_CNT_W            = 9;
    localparam int         DIV_BASE_LOG2        = 2;
endpackage : sr_sel_pkg

// *** tb/sr_latch_input_select_test.sv ***
// self-checking bench of the latch input selection block
`timescale 1ns/1ps
`default_nettype none
module sr_latch_input_select_test;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, pin, c1, c2, lset, lrst, pclk, len, qen, nqen, err, prev;
    logic [7:0]  en;
    logic [2:0]  v;
    int          fail_count = 0, n_tests = 0, cnt;
    localparam logic [11:0] CTRL = sr_sel_pkg::ADDR_CONTROL_MAIN;
    localparam logic [11:0] SRC  = sr_sel_pkg::ADDR_SOURCE_ENABLES;
    always #20 clk = ~clk;
    sr_latch_input_select u_sr_latch_input_select (.i_sys_clk(clk), .i_rst(rst),
        .i_clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'h1), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .i_latch_input_pin(pin), .i_comparator_one(c1), .i_comparator_two(c2),
        .o_latch_set(lset), .o_latch_reset(lrst), .o_latch_pulse_clock(pclk),
        .o_latch_enable_bit(len), .o_true_output_enable(qen), .o_inverted_output_enable(nqen));
    sr_sources_model u_sr_sources_model (.i_sys_clk(clk), .o_pin(pin), .o_cmp1(c1),
        .o_cmp2(c2));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    // request held until pready is sampled high at a rising edge; data taken there
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // nibble layout: pin at 3, cmp2 at 1, cmp1 at 0
    function automatic logic exp_src(input logic [3:0] e, input logic [2:0] s);
        return (s[2] & e[3]) | (s[1] & e[1]) | (s[0] & e[0]);
    endfunction : exp_src
    initial
    begin
        #2000000;
        fail_count++;
        close_out();
    end
    initial
    begin
        void'($urandom(75));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, CTRL, 32'h0);
        check(rd, {24'h0, sr_sel_pkg::CONTROL_MAIN_RESET});
        apb(1'b0, SRC, 32'h0);
        check(rd, {24'h0, sr_sel_pkg::SOURCE_ENABLES_RESET});
        // unmapped read answers zero with an error, unmapped write is dropped
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, 12'h008, 32'h0000_00ff);
        apb(1'b0, SRC, 32'h0);
        check(rd, 32'h0);
        repeat (6)
        begin
            en = 8'($urandom);
            apb(1'b1, CTRL, {24'hff_ffff, en});
            apb(1'b0, CTRL, 32'h0);
            check(rd, {24'h0, en & 8'hfc});
            check({29'h0, len, qen, nqen}, {29'h0, en[7], en[3:2]});
        end
        // both soft pulses at once: each must last exactly one cycle
        apb(1'b1, CTRL, 32'h03);
        cnt = 0;
        repeat (4)
        begin
            @(negedge clk);
            cnt += lset + (lrst << 4);
        end
        check(cnt, 32'h11);
        apb(1'b0, CTRL, 32'h0);
        check(rd, 32'h0);
        $display("register and soft pulse tests done");
        apb(1'b1, CTRL, 32'h0);
        repeat (30)
        begin
            en = 8'($urandom) & 8'hbb;
            en[3:0] = en[3:0] & ~en[7:4];
            apb(1'b1, SRC, {24'h0, en});
            repeat (4)
            begin
                v = 3'($urandom);
                u_sr_sources_model.drive(v);
                @(posedge clk);
                @(negedge clk);
                check({31'h0, lset}, {31'h0, exp_src(en[7:4], v)});
                check({31'h0, lrst}, {31'h0, exp_src(en[3:0], v)});
            end
        end
        u_sr_sources_model.drive(3'h0);
        $display("source selection test done");
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, SRC, k ? 32'h04 : 32'h40);
            @(negedge clk);
            prev = pclk;
            cnt = 0;
            repeat (40)
            begin
                @(negedge clk);
                check({31'h0, k ? lrst : lset}, {31'h0, prev});
                check({31'h0, k ? lset : lrst}, 32'h0);
                if (pclk && cnt != 0)
                    check(cnt, 32'h4);
                cnt = pclk ? 1 : (cnt != 0 ? cnt + 1 : 0);
                prev = pclk;
            end
        end
        // every divider setting: spacing between two pulses is 4 << sel
        for (int s = 0; s < 8; s++)
        begin
            apb(1'b1, CTRL, {24'h0, 1'b0, 3'(s), 4'h0});
            cnt = 0;
            @(negedge clk);
            while (pclk !== 1'b1 && cnt < 1100)
            begin
                @(negedge clk);
                cnt++;
            end
            cnt = 0;
            do
            begin
                @(negedge clk);
                cnt++;
            end
            while (pclk !== 1'b1 && cnt < 1100);
            check(cnt, 32'(4 << s));
        end
        $display("pulse clock test done");
        close_out();
    end
endmodule : sr_latch_input_select_test
`default_nettype wire

// *** tb/sr_sources_model.sv ***
// far-side sources: latch input pin and two comparator outputs
`timescale 1ns/1ps
`default_nettype none
module sr_sources_model
(
    input  wire logic i_sys_clk,
    output logic      o_pin,
    output logic      o_cmp1,
    output logic      o_cmp2
);
    initial {o_pin, o_cmp2, o_cmp1} = 3'h0;
    // levels move just after an edge, then hold for the whole cycle
    task automatic drive(input logic [2:0] v);
        @(posedge i_sys_clk);
        {o_pin, o_cmp2, o_cmp1} <= v;
    endtask : drive
endmodule : sr_sources_model
`default_nettype wire
